// File: src/urxw_pkg.sv
// Constants for the receive-side serial extensions block
package urxw_pkg;
    localparam logic [5:0]  IDX_RXDL  = 6'h00;
    localparam logic [5:0]  IDX_RXDH  = 6'h01;
    localparam logic [5:0]  IDX_STAT  = 6'h04;
    localparam logic [5:0]  IDX_CTLA  = 6'h05;
    localparam logic [5:0]  IDX_CTLB  = 6'h06;
    localparam logic [5:0]  IDX_CTLC  = 6'h07;
    localparam logic [5:0]  IDX_BAUD  = 6'h08;
    localparam logic [5:0]  IDX_EVCT  = 6'h0C;
    localparam logic [5:0]  IDX_TXPL  = 6'h0D;
    localparam logic [5:0]  IDX_RXPL  = 6'h0E;
    // Bit positions: status, control A, control B, control C, data high, event
    localparam int          B_RXCF    = 7;
    localparam int          B_SDF     = 4;
    localparam int          B_SMF     = 3;
    localparam int          B_BDF     = 1;
    localparam int          B_WFB     = 0;
    localparam int          B_RXCIE   = 7;
    localparam int          B_START_IRQ_ENABLE   = 4;
    localparam int          B_SWIRE   = 3;
    localparam int          B_AUTORATE_ERROR_IRQ_ENABLE   = 2;
    localparam int          B_RXEN    = 7;
    localparam int          B_START_DETECT_ENABLE   = 4;
    localparam int          B_RXM     = 1;
    localparam int          B_MULTIPROC_FILTER_ENABLE    = 0;
    localparam int          B_COMM_MODE_FIELD   = 6;
    localparam int          B_FERR    = 2;
    localparam int          B_INFRARED_EVENT_INPUT_ENABLE    = 0;
    localparam logic [15:0] RST_BAUD  = 16'h0000;
    localparam logic [1:0]  RXM_GEN   = 2'h2;
    localparam logic [1:0]  RXM_LIN   = 2'h3;
    localparam logic [1:0]  CM_ASYNC  = 2'h0;
    localparam logic [1:0]  CM_IR     = 2'h2;
    localparam logic [1:0]  SL_ACT    = 2'h0;
    localparam logic [1:0]  SL_IDLE   = 2'h1;
    localparam logic [1:0]  SL_STBY   = 2'h2;
    localparam logic [7:0]  SYNC_CHAR = 8'h55;
    localparam logic [15:0] BAUD_MIN  = 16'h0064;
    localparam logic [17:0] BRK_BITS  = 18'h0000B;
    localparam logic [7:0]  TXPL_316  = 8'h00;
    localparam logic [7:0]  TXPL_OFF  = 8'hFF;
    localparam logic [2:0]  SYNC_FALL = 3'h3;
    typedef enum logic [1:0] {RS_IDLE, RS_START, RS_DATA, RS_STOP} urxw_rx_type;
endpackage : urxw_pkg

// File: src/urxw_top.sv
// Receive-side serial extensions with APB register access
`timescale 1ns/10ps
module urxw_top #(
    parameter int ADDR_W = 8
) (
    input  logic              pclk,
    input  logic              presetn,
    input  logic              psel,
    input  logic              penable,
    input  logic              pwrite,
    input  logic [ADDR_W-1:0] paddr,
    input  logic [31:0]       pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  logic              rxd_pin,
    input  logic              event_in,
    input  logic              tx_serial,
    input  logic              tx_busy,
    input  logic [1:0]        sleep_mode,
    input  logic              other_wake,
    output logic              txd_pin,
    output logic              irq,
    output logic              osc_request,
    output logic              serial_clk_enable,
    output logic              wake_request
);
    // Bit period in clocks: divider holds 64ths of a 16x sample period
    function automatic logic [13:0] bit_per(input logic [15:0] b);
        bit_per = (b[15:2] == 14'h0000) ? 14'h0001 : b[15:2];
    endfunction : bit_per

    function automatic logic [3:0] n_bits(input logic [2:0] cs);
        case (cs)
            3'h0, 3'h1, 3'h2, 3'h3: n_bits = 4'h5 + {1'b0, cs};
            3'h6, 3'h7:             n_bits = 4'h9;
            default:                n_bits = 4'h8;
        endcase
    endfunction : n_bits

    logic [7:0]  ctla_reg, ctlb_reg, ctlc_reg, txpl_reg;
    logic [6:0]  rxpl_reg;
    logic        infrared_event_input_enable_reg;
    logic [15:0] baud_reg;
    logic        rxcf_reg, sdf_reg, smf_reg, bdf_reg, wfb_reg;
    logic [8:0]  rxd_reg;
    logic        ferr_reg;
    logic [31:0] prdata_reg;
    urxw_pkg::urxw_rx_type st_reg;
    logic [13:0] tcnt_reg;
    logic [3:0]  bcnt_reg;
    logic [8:0]  sh_reg;
    logic        rx_prev_reg, clk_run_reg, sync_pend_reg, wfb_fall_reg;
    logic [17:0] lowc_reg;
    logic        meas_on_reg, meas_done_reg, pre_reg;
    logic [2:0]  fcnt_reg;
    logic [16:0] mcnt_reg;
    logic        tx_prev_reg, txd_reg;
    logic [13:0] txt_reg, pcnt_reg;
    logic [7:0]  irlow_reg;
    logic [13:0] irht_reg;
    logic        irq_reg;

    wire [5:0]  idx     = paddr[7:2];
    wire        acc     = psel & penable;
    wire        wr      = acc & pwrite;
    wire        rxen    = ctlb_reg[urxw_pkg::B_RXEN];
    wire [1:0]  receive_mode_field  = ctlb_reg[urxw_pkg::B_RXM +: 2];
    wire        multiproc_filter_enable    = ctlb_reg[urxw_pkg::B_MULTIPROC_FILTER_ENABLE];
    wire [1:0]  comm_mode_field   = ctlc_reg[urxw_pkg::B_COMM_MODE_FIELD +: 2];
    wire [2:0]  chsize  = ctlc_reg[2:0];
    wire        ir_mode = (comm_mode_field == urxw_pkg::CM_IR);
    wire        lin     = (receive_mode_field == urxw_pkg::RXM_LIN);
    wire        autom   = lin | (receive_mode_field == urxw_pkg::RXM_GEN);
    wire [13:0] bitper  = bit_per(baud_reg);
    wire [3:0]  nbits   = n_bits(chsize);
    wire        hit     = (idx == urxw_pkg::IDX_RXDL) | (idx == urxw_pkg::IDX_RXDH)
                        | (idx == urxw_pkg::IDX_STAT) | (idx == urxw_pkg::IDX_CTLA)
                        | (idx == urxw_pkg::IDX_CTLB) | (idx == urxw_pkg::IDX_CTLC)
                        | (idx == urxw_pkg::IDX_BAUD) | (idx == urxw_pkg::IDX_EVCT)
                        | (idx == urxw_pkg::IDX_TXPL) | (idx == urxw_pkg::IDX_RXPL);
    wire        w_stat  = wr & (idx == urxw_pkg::IDX_STAT);
    wire        rd_pop  = acc & ~pwrite & (idx == urxw_pkg::IDX_RXDL);

    // event input replaces the pin; transmit output looped back
    wire        ir_src  = infrared_event_input_enable_reg ? event_in : rxd_pin;
    wire        rx_raw  = ctla_reg[urxw_pkg::B_SWIRE] ? txd_reg : ir_src;
    wire        ir_lo   = ~rx_raw;
    // pulse qualifies once it has lasted the minimum width
    wire [7:0]  irlow_n = irlow_reg + 8'h01;
    wire        ir_q    = ir_lo & (irlow_n >= {1'b0, rxpl_reg});
    wire        ir_dec  = ~(irht_reg != 14'h0000);
    // infrared codec sits in the receive path
    wire        rx_now  = ir_mode ? ir_dec : rx_raw;
    wire        rx_fall = rx_prev_reg & ~rx_now;
    wire        rx_rise = ~rx_prev_reg & rx_now;

    wire        standby = (sleep_mode == urxw_pkg::SL_STBY);
    wire        awake   = (sleep_mode == urxw_pkg::SL_ACT) | (sleep_mode == urxw_pkg::SL_IDLE);
    // start detector armed only in async standby
    wire        sfd_act = ctlb_reg[urxw_pkg::B_START_DETECT_ENABLE] & (comm_mode_field == urxw_pkg::CM_ASYNC) & standby;
    wire        sfd_go  = sfd_act & rxen & rx_fall & (st_reg == urxw_pkg::RS_IDLE) & ~clk_run_reg;
    wire        rx_run  = awake | clk_run_reg | sfd_go;

    wire        t0      = (tcnt_reg == 14'h0000);
    wire        f_start = (st_reg == urxw_pkg::RS_START) & t0 & rx_now;
    wire        f_done  = (st_reg == urxw_pkg::RS_STOP) & t0;
    // frame type: ninth bit for 9-bit frames, else first stop bit
    wire        nine    = (nbits == 4'h9);
    wire        addr_f  = nine ? sh_reg[8] : rx_now;
    wire [8:0]  dmask   = 9'h1FF >> (4'h9 - nbits);

    // break is more than 11 low bit times
    wire [17:0] brk_thr = 18'({4'h0, bitper} * urxw_pkg::BRK_BITS);
    wire        brk_hit = autom & rx_run & ~rx_now & (lowc_reg == brk_thr);
    // fall then rise is a break when waiting for one
    wire        wfb_brk = wfb_fall_reg & rx_rise;
    wire        brk_ev  = brk_hit | wfb_brk;

    // evaluate the sync field when its frame ends
    wire        s_eval  = f_done & sync_pend_reg;
    wire        m_ok    = meas_done_reg & ~mcnt_reg[16];
    wire        lin_ok  = (sh_reg[7:0] == urxw_pkg::SYNC_CHAR) & rx_now;
    wire        gen_ok  = (mcnt_reg[15:0] >= urxw_pkg::BAUD_MIN);
    wire        s_upd   = s_eval & m_ok & (lin ? lin_ok : gen_ok);
    wire        accept  = f_done & ~sync_pend_reg & rxen & (~multiproc_filter_enable | addr_f);

    wire        w_ctla  = wr & (idx == urxw_pkg::IDX_CTLA);
    wire        w_ctlb  = wr & (idx == urxw_pkg::IDX_CTLB);
    wire        w_ctlc  = wr & (idx == urxw_pkg::IDX_CTLC);
    wire        w_baud  = wr & (idx == urxw_pkg::IDX_BAUD);
    wire        w_evct  = wr & (idx == urxw_pkg::IDX_EVCT);
    wire        w_txpl  = wr & (idx == urxw_pkg::IDX_TXPL);
    wire        w_rxpl  = wr & (idx == urxw_pkg::IDX_RXPL);
    wire [7:0]  stat_v  = {rxcf_reg, 2'b00, sdf_reg, smf_reg, 1'b0, bdf_reg, wfb_reg};
    wire [7:0]  rxdh_v  = {rxcf_reg, 4'h0, ferr_reg, 1'b0, rxd_reg[8]};
    wire [31:0] rdmux   =
        (idx == urxw_pkg::IDX_RXDL) ? {24'h000000, rxd_reg[7:0]} :
        (idx == urxw_pkg::IDX_RXDH) ? {24'h000000, rxdh_v} :
        (idx == urxw_pkg::IDX_STAT) ? {24'h000000, stat_v} :
        (idx == urxw_pkg::IDX_CTLA) ? {24'h000000, ctla_reg} :
        (idx == urxw_pkg::IDX_CTLB) ? {24'h000000, ctlb_reg} :
        (idx == urxw_pkg::IDX_CTLC) ? {24'h000000, ctlc_reg} :
        (idx == urxw_pkg::IDX_BAUD) ? {16'h0000, baud_reg} :
        (idx == urxw_pkg::IDX_EVCT) ? {31'h00000000, infrared_event_input_enable_reg} :
        (idx == urxw_pkg::IDX_TXPL) ? {24'h000000, txpl_reg} :
        (idx == urxw_pkg::IDX_RXPL) ? {25'h0000000, rxpl_reg} : 32'h00000000;

    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata  = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (psel & ~penable) begin
            prdata_reg <= rdmux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctla_reg <= 8'h00;
            ctlb_reg <= 8'h00;
            ctlc_reg <= 8'h00;
            infrared_event_input_enable_reg <= 1'b0;
            txpl_reg <= 8'h00;
            rxpl_reg <= 7'h00;
        end else begin
            if (w_ctla) ctla_reg <= pwdata[7:0];
            if (w_ctlb) ctlb_reg <= pwdata[7:0];
            if (w_ctlc) ctlc_reg <= pwdata[7:0];
            if (w_evct) infrared_event_input_enable_reg <= pwdata[urxw_pkg::B_INFRARED_EVENT_INPUT_ENABLE];
            if (w_txpl) txpl_reg <= pwdata[7:0];
            if (w_rxpl) rxpl_reg <= pwdata[6:0];
        end
    end

    // measured value replaces the divider after a valid sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) baud_reg <= urxw_pkg::RST_BAUD;
        else if (s_upd) baud_reg <= mcnt_reg[15:0];
        else if (w_baud) baud_reg <= pwdata[15:0];
    end

    // flags SDF, SMF, BDF: hardware set wins over write-one clear; WFB is set by writing one and a break clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdf_reg <= 1'b0;
            smf_reg <= 1'b0;
            bdf_reg <= 1'b0;
            wfb_reg <= 1'b0;
        end else begin
            sdf_reg <= sfd_go | (sdf_reg & ~(w_stat & pwdata[urxw_pkg::B_SDF]));
            smf_reg <= (s_eval & ~s_upd) | (smf_reg & ~(w_stat & pwdata[urxw_pkg::B_SMF]));
            bdf_reg <= brk_ev | (bdf_reg & ~(w_stat & pwdata[urxw_pkg::B_BDF]));
            wfb_reg <= ~brk_ev & (wfb_reg | (w_stat & pwdata[urxw_pkg::B_WFB]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxcf_reg <= 1'b0;
            rxd_reg  <= 9'h000;
            ferr_reg <= 1'b0;
        end else if (accept) begin
            rxcf_reg <= 1'b1;
            rxd_reg  <= sh_reg & dmask;
            ferr_reg <= ~rx_now;
        end else if (rd_pop | ~rxen) begin
            rxcf_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg   <= urxw_pkg::RS_IDLE;
            tcnt_reg <= 14'h0000;
            bcnt_reg <= 4'h0;
            sh_reg   <= 9'h000;
        end else if (~rxen | ~rx_run | brk_ev) begin
            st_reg   <= urxw_pkg::RS_IDLE;
        end else begin
            case (st_reg)
                urxw_pkg::RS_IDLE: if (rx_fall) begin
                    st_reg   <= urxw_pkg::RS_START;
                    tcnt_reg <= bitper >> 1;
                end
                urxw_pkg::RS_START: if (!t0) begin
                    tcnt_reg <= tcnt_reg - 14'h0001;
                end else if (rx_now) begin
                    st_reg   <= urxw_pkg::RS_IDLE;
                end else begin
                    st_reg   <= urxw_pkg::RS_DATA;
                    tcnt_reg <= bitper - 14'h0001;
                    bcnt_reg <= 4'h0;
                    sh_reg   <= 9'h000;
                end
                urxw_pkg::RS_DATA: if (!t0) begin
                    tcnt_reg <= tcnt_reg - 14'h0001;
                end else begin
                    sh_reg[bcnt_reg] <= rx_now;
                    bcnt_reg <= bcnt_reg + 4'h1;
                    tcnt_reg <= bitper - 14'h0001;
                    if (bcnt_reg == nbits - 4'h1) st_reg <= urxw_pkg::RS_STOP;
                end
                urxw_pkg::RS_STOP: if (!t0) begin
                    tcnt_reg <= tcnt_reg - 14'h0001;
                end else begin
                    st_reg   <= urxw_pkg::RS_IDLE;
                end
                default: st_reg <= urxw_pkg::RS_IDLE;
            endcase
        end
    end

    // serial clock held by the start detector in standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) clk_run_reg <= 1'b0;
        else if (sfd_go) clk_run_reg <= 1'b1;
        else if ((f_start & ~other_wake) | f_done | ~standby) clk_run_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev_reg   <= 1'b1;
            lowc_reg      <= 18'h00000;
            wfb_fall_reg  <= 1'b0;
            sync_pend_reg <= 1'b0;
        end else begin
            rx_prev_reg   <= rx_now;
            lowc_reg      <= (rx_now | ~rx_run) ? 18'h00000 :
                             (&lowc_reg) ? lowc_reg : lowc_reg + 18'h00001;
            wfb_fall_reg  <= wfb_reg & ~brk_ev & (wfb_fall_reg | rx_fall);
            sync_pend_reg <= brk_ev | (sync_pend_reg & ~s_eval);
        end
    end

    // counter steps every second clock over the 8 sync bit times
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_on_reg   <= 1'b0;
            meas_done_reg <= 1'b0;
            pre_reg       <= 1'b0;
            fcnt_reg      <= 3'h0;
            mcnt_reg      <= 17'h00000;
        end else if (brk_ev) begin
            meas_on_reg   <= 1'b0;
            meas_done_reg <= 1'b0;
        end else if (sync_pend_reg & ~meas_on_reg & ~meas_done_reg & rx_fall) begin
            meas_on_reg   <= 1'b1;
            pre_reg       <= 1'b0;
            fcnt_reg      <= 3'h0;
            mcnt_reg      <= 17'h00000;
        end else if (meas_on_reg) begin
            pre_reg <= ~pre_reg;
            if (pre_reg & ~mcnt_reg[16]) mcnt_reg <= mcnt_reg + 17'h00001;
            if (rx_fall) begin
                fcnt_reg <= fcnt_reg + 3'h1;
                if (fcnt_reg == urxw_pkg::SYNC_FALL) begin
                    meas_on_reg   <= 1'b0;
                    meas_done_reg <= 1'b1;
                end
            end
        end
    end

    // transmit pulse: 3/16 bit, fixed clock count, or none
    wire        tx_bs   = (tx_prev_reg ^ tx_serial) | (txt_reg == 14'h0000);
    wire [17:0] p316    = 18'({4'h0, bitper} * 18'h00003);
    wire [13:0] pw      = (txpl_reg == urxw_pkg::TXPL_316) ? p316[17:4] : {6'h00, txpl_reg};
    wire        nomod   = (txpl_reg == urxw_pkg::TXPL_OFF);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_prev_reg <= 1'b1;
            txt_reg     <= 14'h0000;
            pcnt_reg    <= 14'h0000;
            txd_reg     <= 1'b1;
        end else begin
            tx_prev_reg <= tx_serial;
            txt_reg     <= tx_bs ? bitper - 14'h0001 : txt_reg - 14'h0001;
            pcnt_reg    <= (tx_bs & ~tx_serial) ? pw :
                           (pcnt_reg != 14'h0000) ? pcnt_reg - 14'h0001 : 14'h0000;
            // pin is the inverse of the infrared pulse
            txd_reg     <= (ir_mode & ~nomod) ? (pcnt_reg == 14'h0000) : tx_serial;
        end
    end

    // a qualified pulse decodes as zero for one bit period
    wire [13:0] ir_hold = ({6'h00, irlow_reg} < bitper) ? bitper - {6'h00, irlow_reg} : bitper;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irlow_reg     <= 8'h00;
            irht_reg      <= 14'h0000;
        end else begin
            irlow_reg     <= ~ir_lo ? 8'h00 : (&irlow_reg) ? irlow_reg : irlow_n;
            if (ir_q & (irht_reg == 14'h0000)) irht_reg <= ir_hold;
            else if (irht_reg != 14'h0000) irht_reg <= irht_reg - 14'h0001;
        end
    end

    // shared receive interrupt; wake follows it in standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_reg <= 1'b0;
        else irq_reg <= (rxcf_reg & ctla_reg[urxw_pkg::B_RXCIE])
                      | (sdf_reg & ctla_reg[urxw_pkg::B_START_IRQ_ENABLE])
                      | (smf_reg & ctla_reg[urxw_pkg::B_AUTORATE_ERROR_IRQ_ENABLE]);
    end
    assign irq               = irq_reg;
    assign txd_pin           = txd_reg;
    assign serial_clk_enable = clk_run_reg;
    assign wake_request      = standby & irq_reg;
    // oscillator kept while a transfer is running
    assign osc_request       = clk_run_reg | (st_reg != urxw_pkg::RS_IDLE) | tx_busy;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_sfd_start;
        sfd_go;
    endsequence
    sequence s_woken;
        clk_run_reg && osc_request && sdf_reg;
    endsequence
    property p_sfd_gate;
        $rose(clk_run_reg) |-> $past(sfd_act);
    endproperty
    a_sfd_gate: assert property (p_sfd_gate) else $error("clock started outside standby detect");
    property p_sfd_wake;
        s_sfd_start |=> s_woken;
    endproperty
    a_sfd_wake: assert property (p_sfd_wake) else $error("start edge did not wake");
    property p_false_off;
        f_start && !other_wake && !sfd_go |=> !clk_run_reg;
    endproperty
    a_false_off: assert property (p_false_off) else $error("clock kept after false start");
    property p_irq;
        (rxcf_reg && ctla_reg[urxw_pkg::B_RXCIE]) || (sdf_reg && ctla_reg[urxw_pkg::B_START_IRQ_ENABLE])
            |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("shared interrupt missing");
    property p_osc;
        st_reg != urxw_pkg::RS_IDLE |-> osc_request;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator dropped mid frame");
    property p_lin_bad;
        s_eval && lin && !lin_ok |=> smf_reg && $stable(baud_reg);
    endproperty
    a_lin_bad: assert property (p_lin_bad) else $error("bad sync changed divider");
    property p_upd;
        s_upd |=> baud_reg == $past(mcnt_reg[15:0])
            && ($past(lin) || baud_reg >= urxw_pkg::BAUD_MIN);
    endproperty
    a_upd: assert property (p_upd) else $error("divider not taken from count");
    property p_filter;
        f_done && multiproc_filter_enable && !addr_f && !rxcf_reg |=> !rxcf_reg;
    endproperty
    a_filter: assert property (p_filter) else $error("data frame passed filter");
    property p_brk;
        brk_ev |=> sync_pend_reg && !wfb_reg && st_reg == urxw_pkg::RS_IDLE;
    endproperty
    a_brk: assert property (p_brk) else $error("break not handled");
endmodule : urxw_top

// File: dv/urxw_far_tx.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/10ps
module urxw_far_tx (
    input  wire logic pclk,
    output logic      line
);
    initial line = 1'h1;
    task automatic send(input logic [7:0] d, input logic t, input int per);
        logic [10:0] f;
        f = {1'h1, t, d, 1'h0};
        for (int i = 0; i < 11; i++) begin
            line <= f[i];
            repeat (per) @(posedge pclk);
        end
    endtask : send
    // Low run, then idle high as the pull-up leaves it
    task automatic brk(input int n);
        line <= 1'h0;
        repeat (n) @(posedge pclk);
        line <= 1'h1;
        repeat (8) @(posedge pclk);
    endtask : brk
endmodule : urxw_far_tx

// File: dv/tb_uart_rx_wake_autobaud_ext.sv
// Self-checking bench for the receive-side serial extensions
`timescale 1ns/10ps
module tb_uart_rx_wake_autobaud_ext;
    typedef struct packed {logic [5:0] i; logic [31:0] d; logic [31:0] e; logic b;} urxw_row_type;
    logic         pclk, presetn, psel, penable, pwrite, tx_busy, sw, err, pready, pslverr, ev, ow;
    logic         txd_pin, irq, osc_request, serial_clk_enable, wake_request, far_line;
    logic [1:0]   sleep_mode;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd;
    int           error_cnt, num_checks, cyc;
    urxw_row_type rows [8];
    urxw_far_tx far (.pclk(pclk), .line(far_line));
    urxw_top #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_pin(sw | far_line), .event_in(ev), .tx_serial(~sw | far_line),
        .tx_busy(tx_busy), .sleep_mode(sleep_mode), .other_wake(ow), .txd_pin(txd_pin),
        .irq(irq), .osc_request(osc_request), .serial_clk_enable(serial_clk_enable),
        .wake_request(wake_request));
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        apb(1'h1, i, d);
    endtask : wr
    task automatic rdck(input logic [5:0] i, input logic [31:0] e);
        apb(1'h0, i, 32'h0);
        check($sformatf("reg %h", i), rd, e);
    endtask : rdck
    task automatic pulse_check(input string n, input logic sel, input logic [31:0] e);
        fork
            far.brk(6);
            begin
                repeat (5) @(posedge pclk);
                check(n, 32'(sel ? txd_pin : serial_clk_enable), e);
            end
        join
    endtask : pulse_check
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, tx_busy, sw, ow, paddr, pwdata, sleep_mode} = '0;
        ev = 1'h1;
        rows = '{{6'h05, 32'hFF, 32'hFF, 1'h0}, {6'h06, 32'hFF, 32'hFF, 1'h0},
                 {6'h07, 32'hFF, 32'hFF, 1'h0}, {6'h0C, 32'hFF, 32'h01, 1'h0},
                 {6'h0D, 32'hFF, 32'hFF, 1'h0}, {6'h0E, 32'hFF, 32'h7F, 1'h0},
                 {6'h08, 32'h12345678, 32'h5678, 1'h0}, {6'h0A, 32'hFF, 32'h00, 1'h1}};
        repeat (2) @(posedge pclk);
        check("reset", 32'({irq, txd_pin, serial_clk_enable}), 32'h2);
        presetn <= 1'h1;
        @(posedge pclk);
        foreach (rows[k]) begin
            wr(rows[k].i, rows[k].d);
            rdck(rows[k].i, rows[k].e);
            check("slverr", 32'(err), 32'(rows[k].b));
        end
        wr(6'h07, 32'h03);
        wr(6'h08, 32'h40);
        wr(6'h05, 32'h80);
        wr(6'h06, 32'h80);
        far.send(8'h11, 1'h1, 16);
        check("irq", 32'(irq), 32'h0);
        ev <= 1'h0;
        repeat (20) @(posedge pclk);
        ev <= 1'h1;
        repeat (160) @(posedge pclk);
        rdck(6'h00, 32'hFF);
        wr(6'h0C, 32'h00);
        far.send(8'hA5, 1'h1, 16);
        check("irq", 32'(irq), 32'h1);
        rdck(6'h00, 32'hA5);
        repeat (2) @(posedge pclk);
        check("irq", 32'(irq), 32'h0);
        wr(6'h06, 32'h81);
        far.send(8'h3C, 1'h0, 16);
        check("irq", 32'(irq), 32'h0);
        far.send(8'h7E, 1'h1, 16);
        rdck(6'h00, 32'h7E);
        wr(6'h06, 32'h80);
        wr(6'h05, 32'h88);
        sw <= 1'h1;
        far.send(8'h5A, 1'h1, 16);
        rdck(6'h00, 32'h5A);
        sw <= 1'h0;
        wr(6'h05, 32'h80);
        wr(6'h06, 32'h90);
        far.brk(4);
        rdck(6'h04, 32'h00);
        sleep_mode <= 2'h2;
        pulse_check("sclk", 1'h0, 32'h1);
        repeat (4) @(posedge pclk);
        check("sclk", 32'(serial_clk_enable), 32'h0);
        check("wake", 32'(wake_request), 32'h0);
        rdck(6'h04, 32'h10);
        wr(6'h04, 32'h10);
        wr(6'h05, 32'h90);
        far.brk(6);
        check("wake", 32'(wake_request), 32'h1);
        tx_busy <= 1'h1;
        @(posedge pclk);
        check("osc", 32'(osc_request), 32'h1);
        ow <= 1'h1;
        far.brk(6);
        check("sclk", 32'(serial_clk_enable), 32'h1);
        {tx_busy, sleep_mode, ow} <= '0;
        wr(6'h04, 32'h10);
        wr(6'h08, 32'h100);
        wr(6'h06, 32'h86);
        far.brk(800);
        far.send(8'h55, 1'h1, 62);
        rdck(6'h08, 32'hF8);
        rdck(6'h04, 32'h82);
        wr(6'h04, 32'h02);
        far.brk(800);
        far.send(8'h54, 1'h1, 62);
        rdck(6'h04, 32'h8A);
        rdck(6'h08, 32'hF8);
        wr(6'h04, 32'h0A);
        wr(6'h06, 32'h84);
        far.brk(800);
        far.send(8'h55, 1'h1, 60);
        rdck(6'h08, 32'hF0);
        wr(6'h04, 32'h03);
        far.brk(3);
        rdck(6'h04, 32'h82);
        wr(6'h0E, 32'h03);
        wr(6'h07, 32'h83);
        wr(6'h04, 32'h03);
        far.brk(2);
        rdck(6'h04, 32'h81);
        far.brk(4);
        repeat (60) @(posedge pclk);
        rdck(6'h04, 32'h82);
        wr(6'h0D, 32'h02);
        sw <= 1'h1;
        pulse_check("txd", 1'h1, 32'h1);
        wr(6'h0D, 32'hFF);
        pulse_check("txd", 1'h1, 32'h0);
        sw <= 1'h0;
        close_out();
    end
endmodule : tb_uart_rx_wake_autobaud_ext
